/* core/pwm_pkg.sv */
package pwm_pkg;

	// ****************************************
	// register map (word addresses)
	// ****************************************
	localparam logic [3:0] ADDR_HALF_PERIOD = 4'h0;
	localparam logic [3:0] ADDR_DEAD_TIME   = 4'h1;
	localparam logic [3:0] ADDR_MIN_PULSE   = 4'h2;
	localparam logic [3:0] ADDR_SYNC_WIDTH  = 4'h3;
	localparam logic [3:0] ADDR_DUTY_A      = 4'h4;
	localparam logic [3:0] ADDR_DUTY_B      = 4'h5;
	localparam logic [3:0] ADDR_DUTY_C      = 4'h6;
	localparam logic [3:0] ADDR_MODE_CTRL   = 4'h7;
	localparam logic [3:0] ADDR_SYS_STATUS  = 4'h8;

	// ****************************************
	// fields and reset values
	// ****************************************
	localparam int           MODE_DOUBLE_BIT  = 6;
	localparam int           STAT_HALF_BIT    = 3;
	localparam int           STAT_RUN_BIT     = 1;
	localparam int           DEAD_TIME_BITS   = 10;
	localparam int           SYNC_WIDTH_BITS  = 8;
	localparam logic [7:0]   SYNC_WIDTH_RST   = 8'h27;
	localparam logic [15:0]  HALF_PERIOD_RST  = 16'h0000;
	localparam logic [15:0]  DUTY_RST         = 16'h0000;

	// ****************************************
	// shared types
	// ****************************************
	typedef struct packed {
		logic [15:0] half_period_count;
		logic [9:0]  dead_time_count;
		logic [15:0] min_pulse_count;
		logic [7:0]  sync_width_count;
		logic [15:0] duty_phase_a;
		logic [15:0] duty_phase_b;
		logic [15:0] duty_phase_c;
	} pwm_cfg_t;

	typedef struct packed {
		logic high;
		logic low;
	} pwm_pair_t;

endpackage

/* core/pwm_phase_leg.sv */
`timescale 1ns/1ps
`default_nettype none

// one complementary output pair for one phase, over both half periods
module pwm_phase_leg
	import pwm_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        nrst,
	input  wire logic        run,
	input  wire logic        second_half,
	input  wire logic [15:0] count,
	input  wire logic [15:0] half_period,
	input  wire logic [15:0] duty,
	input  wire logic [9:0]  dead_time,
	input  wire logic [15:0] min_pulse,
	output pwm_pair_t        pair
);

	// saturating difference
	function automatic logic [16:0] sat_sub(input logic [16:0] a, input logic [16:0] b);
		sat_sub = (a > b) ? 17'(a - b) : 17'h00000;
	endfunction

	logic [16:0] hi_on;
	logic [16:0] lo_on;
	logic [16:0] hi_lo_edge;
	logic [16:0] hi_hi_edge;
	logic        hi_kill;
	logic        lo_kill;
	logic [16:0] pos;
	pwm_pair_t   pair_nxt;

	always_comb begin
		// on-time per half, clamped at zero and at the half period
		hi_on   = sat_sub({1'b0, duty}, {7'h00, dead_time});
		if (hi_on > {1'b0, half_period}) begin
			hi_on = {1'b0, half_period};
		end
		lo_on   = sat_sub(sat_sub({1'b0, half_period}, {1'b0, duty}), {7'h00, dead_time});
		hi_kill = hi_on < {1'b0, min_pulse};
		lo_kill = lo_on < {1'b0, min_pulse};
		// position measured from the period centre: first half counts down
		pos = second_half ? {1'b0, count} : sat_sub({1'b0, half_period}, {1'b0, count} + 17'h00001);
		// edges shifted by dead time both sides of the duty instant
		hi_hi_edge = hi_on;
		hi_lo_edge = sat_sub({1'b0, half_period}, lo_on);
		pair_nxt.high = run && !hi_kill && (pos < hi_hi_edge);
		pair_nxt.low  = run && (hi_kill || (!lo_kill && (pos >= hi_lo_edge)));
		if (run && lo_kill && !hi_kill) begin
			pair_nxt.high = 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			pair <= '0;
		end else begin
			pair <= pair_nxt;
		end
	end

endmodule

`default_nettype wire

/* core/pwm_timing_unit.sv */
// Our own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`default_nettype none

module pwm_timing_unit
	import pwm_pkg::*;
#(
	parameter int DUTY_BITS = 16
) (
	input  wire logic        core_clk,
	input  wire logic        nrst,
	input  wire logic [3:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic [15:0]      reg_rdata,
	output logic             phase_a_high_out,
	output logic             phase_a_low_out,
	output logic             phase_b_high_out,
	output logic             phase_b_low_out,
	output logic             phase_c_high_out,
	output logic             phase_c_low_out,
	output logic             period_sync_pulse
);

	// ****************************************
	// software registers
	// ****************************************
	pwm_cfg_t    shadow_r;
	pwm_cfg_t    shadow_nxt;
	logic        double_mode_r;
	logic        double_mode_nxt;
	logic [3:0]  written_r;
	logic [3:0]  written_nxt;
	logic [15:0] reg_rdata_nxt;

	// ****************************************
	// timing state
	// ****************************************
	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0001,
		ST_START = 4'b0010,
		ST_FIRST = 4'b0100,
		ST_SECND = 4'b1000
	} tstate_t;

	tstate_t     state_r;
	tstate_t     state_nxt;
	pwm_cfg_t    active_r;
	pwm_cfg_t    active_nxt;
	logic [16:0] count_r;
	logic [16:0] count_nxt;
	logic [8:0]  sync_cnt_r;
	logic [8:0]  sync_cnt_nxt;
	logic        sync_nxt;
	logic        run;
	logic        second_half;
	logic        latch_now;
	logic        all_written;
	pwm_pair_t   pair_a;
	pwm_pair_t   pair_b;
	pwm_pair_t   pair_c;

	// ****************************************
	// register write/read
	// ****************************************
	always_comb begin
		shadow_nxt      = shadow_r;
		double_mode_nxt = double_mode_r;
		written_nxt     = written_r;
		reg_rdata_nxt   = 16'h0000;
		if (reg_wr) begin
			case (reg_addr)
				ADDR_HALF_PERIOD: begin
					shadow_nxt.half_period_count = reg_wdata;
					written_nxt[0]               = 1'b1;
				end
				ADDR_DEAD_TIME:  shadow_nxt.dead_time_count  = reg_wdata[DEAD_TIME_BITS-1:0];
				ADDR_MIN_PULSE:  shadow_nxt.min_pulse_count  = reg_wdata;
				ADDR_SYNC_WIDTH: shadow_nxt.sync_width_count = reg_wdata[SYNC_WIDTH_BITS-1:0];
				ADDR_DUTY_A: begin
					shadow_nxt.duty_phase_a = reg_wdata;
					written_nxt[1]          = 1'b1;
				end
				ADDR_DUTY_B: begin
					shadow_nxt.duty_phase_b = reg_wdata;
					written_nxt[2]          = 1'b1;
				end
				ADDR_DUTY_C: begin
					shadow_nxt.duty_phase_c = reg_wdata;
					written_nxt[3]          = 1'b1;
				end
				ADDR_MODE_CTRL: double_mode_nxt = reg_wdata[MODE_DOUBLE_BIT];
				default: ;
			endcase
		end
		if (reg_rd) begin
			case (reg_addr)
				ADDR_HALF_PERIOD: reg_rdata_nxt = shadow_r.half_period_count;
				ADDR_DEAD_TIME:   reg_rdata_nxt = {6'h00, shadow_r.dead_time_count};
				ADDR_MIN_PULSE:   reg_rdata_nxt = shadow_r.min_pulse_count;
				ADDR_SYNC_WIDTH:  reg_rdata_nxt = {8'h00, shadow_r.sync_width_count};
				ADDR_DUTY_A:      reg_rdata_nxt = shadow_r.duty_phase_a;
				ADDR_DUTY_B:      reg_rdata_nxt = shadow_r.duty_phase_b;
				ADDR_DUTY_C:      reg_rdata_nxt = shadow_r.duty_phase_c;
				ADDR_MODE_CTRL:   reg_rdata_nxt[MODE_DOUBLE_BIT] = double_mode_r;
				ADDR_SYS_STATUS: begin
					reg_rdata_nxt[STAT_HALF_BIT] = second_half;
					reg_rdata_nxt[STAT_RUN_BIT]  = run;
				end
				default: reg_rdata_nxt = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			shadow_r      <= '{half_period_count: HALF_PERIOD_RST, dead_time_count: '0,
				min_pulse_count: '0, sync_width_count: SYNC_WIDTH_RST,
				duty_phase_a: DUTY_RST, duty_phase_b: DUTY_RST, duty_phase_c: DUTY_RST};
			double_mode_r <= 1'b0;
			written_r     <= 4'h0;
			reg_rdata     <= 16'h0000;
		end else begin
			shadow_r      <= shadow_nxt;
			double_mode_r <= double_mode_nxt;
			written_r     <= written_nxt;
			reg_rdata     <= reg_rdata_nxt;
		end
	end

	// ****************************************
	// half-period timer and sync generation
	// ****************************************
	assign all_written = &written_r;
	assign run         = (state_r == ST_FIRST) || (state_r == ST_SECND);
	assign second_half = (state_r == ST_SECND);

	always_comb begin
		state_nxt    = state_r;
		active_nxt   = active_r;
		count_nxt    = count_r + 17'h00001;
		sync_cnt_nxt = (sync_cnt_r != 9'h000) ? 9'(sync_cnt_r - 9'h001) : 9'h000;
		latch_now    = 1'b0;
		case (state_r)
			ST_IDLE: begin
				count_nxt = 17'h00000;
				// timer starts at the first half-period write
				if (written_r[0] || (reg_wr && reg_addr == ADDR_HALF_PERIOD)) begin
					state_nxt  = ST_START;
					active_nxt = shadow_nxt;
				end
			end
			ST_START: begin
				// single: 1.5 half periods, double: one half period
				if (double_mode_r ? (count_r + 17'h00001 >= {1'b0, active_r.half_period_count})
					: (count_r + 17'h00001 >= 17'({1'b0, active_r.half_period_count}
					+ {2'b00, active_r.half_period_count[15:1]}))) begin
					if (all_written) begin
						state_nxt = ST_FIRST;
						latch_now = 1'b1;
					end else begin
						count_nxt = 17'h00000;
					end
				end
			end
			ST_FIRST: begin
				if (count_r + 17'h00001 >= {1'b0, active_r.half_period_count}) begin
					state_nxt = ST_SECND;
					latch_now = double_mode_r;
					count_nxt = 17'h00000;
				end
			end
			ST_SECND: begin
				if (count_r + 17'h00001 >= {1'b0, active_r.half_period_count}) begin
					state_nxt = ST_FIRST;
					latch_now = 1'b1;
					count_nxt = 17'h00000;
				end
			end
			default: state_nxt = ST_IDLE;
		endcase
		if (latch_now) begin
			active_nxt   = shadow_r;
			count_nxt    = 17'h00000;
			sync_cnt_nxt = {1'b0, shadow_r.sync_width_count} + 9'h001;
		end
		sync_nxt = (sync_cnt_nxt != 9'h000);
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			state_r           <= ST_IDLE;
			active_r          <= '0;
			count_r           <= 17'h00000;
			sync_cnt_r        <= 9'h000;
			period_sync_pulse <= 1'b0;
		end else begin
			state_r           <= state_nxt;
			active_r          <= active_nxt;
			count_r           <= count_nxt;
			sync_cnt_r        <= sync_cnt_nxt;
			period_sync_pulse <= sync_nxt;
		end
	end

	// ****************************************
	// phase legs
	// ****************************************
	pwm_phase_leg u_leg_a (
		.core_clk    (core_clk),
		.nrst        (nrst),
		.run         (run),
		.second_half (second_half),
		.count       (count_r[15:0]),
		.half_period (active_r.half_period_count),
		.duty        (active_r.duty_phase_a),
		.dead_time   (active_r.dead_time_count),
		.min_pulse   (active_r.min_pulse_count),
		.pair        (pair_a)
	);

	pwm_phase_leg u_leg_b (
		.core_clk    (core_clk),
		.nrst        (nrst),
		.run         (run),
		.second_half (second_half),
		.count       (count_r[15:0]),
		.half_period (active_r.half_period_count),
		.duty        (active_r.duty_phase_b),
		.dead_time   (active_r.dead_time_count),
		.min_pulse   (active_r.min_pulse_count),
		.pair        (pair_b)
	);

	pwm_phase_leg u_leg_c (
		.core_clk    (core_clk),
		.nrst        (nrst),
		.run         (run),
		.second_half (second_half),
		.count       (count_r[15:0]),
		.half_period (active_r.half_period_count),
		.duty        (active_r.duty_phase_c),
		.dead_time   (active_r.dead_time_count),
		.min_pulse   (active_r.min_pulse_count),
		.pair        (pair_c)
	);

	assign phase_a_high_out = pair_a.high;
	assign phase_a_low_out  = pair_a.low;
	assign phase_b_high_out = pair_b.high;
	assign phase_b_low_out  = pair_b.low;
	assign phase_c_high_out = pair_c.high;
	assign phase_c_low_out  = pair_c.low;

endmodule

`default_nettype wire

/* bench/pwm_timing_unit_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module pwm_timing_unit_checker
	import pwm_pkg::*;
#(
	parameter int DUTY_BITS = 16
) (
	input wire logic	core_clk,
	input wire logic	nrst,
	input wire logic [3:0]	reg_addr,
	input wire logic [15:0]	reg_wdata,
	input wire logic	reg_wr,
	input wire logic	reg_rd,
	input wire logic [15:0]	reg_rdata,
	input wire logic	phase_a_high_out,
	input wire logic	phase_a_low_out,
	input wire logic	phase_b_high_out,
	input wire logic	phase_b_low_out,
	input wire logic	phase_c_high_out,
	input wire logic	phase_c_low_out,
	input wire logic	period_sync_pulse
);
	// ****
	// setup flags and shadows
	// ****
	logic [3:0]	seen_r;
	logic [3:0]	seen_nxt;
	logic	mode_r;
	logic	mode_nxt;
	logic [15:0]	half_r;
	logic [15:0]	half_nxt;
	always_comb begin
		seen_nxt = seen_r;
		mode_nxt = mode_r;
		half_nxt = half_r;
		if (reg_wr && reg_addr == ADDR_HALF_PERIOD) begin
			seen_nxt[0] = 1'b1;
			half_nxt = reg_wdata;
		end
		if (reg_wr && reg_addr >= ADDR_DUTY_A && reg_addr <= ADDR_DUTY_C)
			seen_nxt[2'(reg_addr[1:0] + 2'd1)] = 1'b1;
		if (reg_wr && reg_addr == ADDR_MODE_CTRL)
			mode_nxt = reg_wdata[MODE_DOUBLE_BIT];
	end
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			seen_r <= 4'h0;
			mode_r <= 1'b0;
			half_r <= 16'h0000;
		end else begin
			seen_r <= seen_nxt;
			mode_r <= mode_nxt;
			half_r <= half_nxt;
		end
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);
	chk_pair_a_apart: assert property (!(phase_a_high_out && phase_a_low_out))
		else $error("phase a overlap");
	chk_pair_b_apart: assert property (!(phase_b_high_out && phase_b_low_out))
		else $error("phase b overlap");
	chk_pair_c_apart: assert property (!(phase_c_high_out && phase_c_low_out))
		else $error("phase c overlap");
	chk_idle_quiet: assert property (seen_r != 4'hf |-> !(period_sync_pulse
		|| phase_a_high_out || phase_a_low_out || phase_b_high_out
		|| phase_b_low_out || phase_c_high_out || phase_c_low_out))
		else $error("output before setup");
	chk_rdata_rest: assert property (!reg_rd |=> reg_rdata == 16'h0000)
		else $error("read data not idle");
	chk_hole_reads: assert property (reg_rd && reg_addr > ADDR_SYS_STATUS
		|=> reg_rdata == 16'h0000)
		else $error("unmapped read not zero");
	chk_mode_echo: assert property (reg_rd && reg_addr == ADDR_MODE_CTRL
		|=> reg_rdata[MODE_DOUBLE_BIT] == mode_r)
		else $error("mode bit readback");
	chk_half_echo: assert property (reg_rd && reg_addr == ADDR_HALF_PERIOD
		|=> reg_rdata == half_r)
		else $error("half period readback");
endmodule
bind pwm_timing_unit pwm_timing_unit_checker #(.DUTY_BITS(DUTY_BITS)) chk_u (
	.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.phase_a_high_out(phase_a_high_out), .phase_a_low_out(phase_a_low_out),
	.phase_b_high_out(phase_b_high_out), .phase_b_low_out(phase_b_low_out),
	.phase_c_high_out(phase_c_high_out), .phase_c_low_out(phase_c_low_out),
	.period_sync_pulse(period_sync_pulse)
);
`default_nettype wire

/* bench/gate_drive_model.sv */
`timescale 1ns/1ps
`default_nettype none
// tallies on-cycles of each gate line per sync interval
module gate_drive_model (
	input wire logic	core_clk,
	input wire logic	nrst,
	input wire logic [5:0]	gate,
	input wire logic	sync,
	output logic [5:0][17:0]	last_on,
	output logic [17:0]	last_len
);
	logic [5:0][17:0]	on_r;
	logic [17:0]	len_r;
	logic	sync_q;
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			on_r <= '0;
			len_r <= '0;
			sync_q <= 1'b0;
			last_on <= '0;
			last_len <= '0;
		end else begin
			sync_q <= sync;
			len_r <= (sync && !sync_q) ? 18'd1 : len_r + 18'd1;
			if (sync && !sync_q) begin
				last_on <= on_r;
				last_len <= len_r;
			end
			for (int i = 0; i < 6; i++)
				on_r[i] <= ((sync && !sync_q) ? 18'd0 : on_r[i]) + 18'(gate[i]);
		end
	end
endmodule
`default_nettype wire

/* bench/three_phase_pwm_duty_timing_test.sv */
`timescale 1ns/1ps
`default_nettype none
module three_phase_pwm_duty_timing_test;
	import pwm_pkg::*;
	localparam int H = 40;
	logic	core_clk = 1'b0;
	logic	nrst = 1'b0;
	logic [3:0]	reg_addr = 4'h0;
	logic [15:0]	reg_wdata = 16'h0000;
	logic	reg_wr = 1'b0;
	logic	reg_rd = 1'b0;
	logic [15:0]	reg_rdata;
	logic [15:0]	v;
	logic	sync;
	logic	sync_q = 1'b0;
	logic	h;
	logic [5:0]	gate;
	logic [5:0][17:0]	last_on;
	logic [17:0]	last_len;
	int	mismatches = 0;
	int	samples_checked = 0;
	int	cyc = 0;
	int	seed = 32'h2b41;
	int	dt, mp, t0, sum;
	int	d[3];
	pwm_timing_unit #(.DUTY_BITS(16)) dut_u (
		.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.phase_a_high_out(gate[0]), .phase_a_low_out(gate[1]),
		.phase_b_high_out(gate[2]), .phase_b_low_out(gate[3]),
		.phase_c_high_out(gate[4]), .phase_c_low_out(gate[5]),
		.period_sync_pulse(sync)
	);
	gate_drive_model gdm_u (.core_clk(core_clk), .nrst(nrst), .gate(gate), .sync(sync),
		.last_on(last_on), .last_len(last_len));
	// ****
	// clock, watchdog and bus tasks
	// ****
	initial begin
		forever #50 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		sync_q <= sync;
		if (cyc == 20000) begin
			mismatches++;
			test_done();
		end
	end
	task automatic wr(input logic [3:0] a, input logic [15:0] w);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= w;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(posedge core_clk);
		v = reg_rdata;
	endtask
	task automatic cmp(input string n, input logic [17:0] e, input logic [17:0] g);
		samples_checked++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %s expected %0d seen %0d", n, e, g);
		end
	endtask
	task automatic wait_sync;
		int n;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (!(sync === 1'b1 && sync_q === 1'b0) && n < 3000);
		cmp("sync_wait", 18'd1, 18'(n < 3000));
	endtask
	function automatic int on_half(int d, int dt, int mp, int lo);
		int a, b;
		a = d - dt;
		b = H - d - dt;
		a = a < 0 ? 0 : (a > H ? H : a);
		b = b < 0 ? 0 : b;
		if (a < mp) begin
			a = 0;
			b = H;
		end else if (b < mp) begin
			b = 0;
			a = H;
		end
		return lo ? b : a;
	endfunction
	task test_done;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge core_clk);
		nrst <= 1'b1;
		rd(4'hf);
		cmp("hole", 18'd0, 18'(v));
		rd(ADDR_SYNC_WIDTH);
		cmp("sync_width", 18'(SYNC_WIDTH_RST), 18'(v));
		rd(ADDR_MODE_CTRL);
		cmp("mode", 18'd0, 18'(v[MODE_DOUBLE_BIT]));
		wr(ADDR_HALF_PERIOD, 16'(H));
		t0 = cyc;
		for (int p = 0; p < 3; p++) wr(ADDR_DUTY_A + 4'(p), 16'(H / 2));
		wait_sync;
		cmp("first_sync", 18'd1, 18'((cyc - t0) inside {[3*H/2-1:3*H/2+2]}));
		repeat (6) begin
			dt = $unsigned($random(seed)) % 8;
			mp = $unsigned($random(seed)) % 12;
			wr(ADDR_DEAD_TIME, 16'(dt));
			wr(ADDR_MIN_PULSE, 16'(mp));
			for (int p = 0; p < 3; p++) begin
				d[p] = $unsigned($random(seed)) % (H + 5);
				wr(ADDR_DUTY_A + 4'(p), 16'(d[p]));
			end
			repeat (4) wait_sync;
			@(negedge core_clk);
			for (int i = 0; i < 6; i++)
				cmp("on_time", 18'(2 * on_half(d[i/2], dt, mp, i % 2)), last_on[i]);
			cmp("period", 18'(2 * H), last_len);
		end
		@(posedge core_clk);
		nrst <= 1'b0;
		repeat (3) @(posedge core_clk);
		nrst <= 1'b1;
		wr(ADDR_MODE_CTRL, 16'h0040);
		wr(ADDR_DEAD_TIME, 16'h0002);
		// sync pulse must be shorter than a half period to show edges
		wr(ADDR_SYNC_WIDTH, 16'h0003);
		d[0] = 10 + $unsigned($random(seed)) % 10;
		wr(ADDR_HALF_PERIOD, 16'(H));
		t0 = cyc;
		for (int p = 0; p < 3; p++) wr(ADDR_DUTY_A + 4'(p), 16'(d[0]));
		wait_sync;
		cmp("first_sync", 18'd1, 18'((cyc - t0) inside {[H-1:H+2]}));
		sum = 0;
		for (int k = 0; k < 8; k++) begin
			rd(ADDR_SYS_STATUS);
			if (k > 0) cmp("half_flag", 18'(!h), 18'(v[STAT_HALF_BIT]));
			h = v[STAT_HALF_BIT];
			wr(ADDR_DUTY_A, 16'(h ? d[0] : d[0] + 1));
			wait_sync;
			@(negedge core_clk);
			cmp("half_len", 18'(H), last_len);
			if (k >= 6) sum += int'(last_on[0]);
		end
		cmp("double_on", 18'(2 * d[0] + 1 - 4), 18'(sum));
		test_done();
	end
endmodule
`default_nettype wire
